// ===== design/fbi_fault_blink.sv
// Fault supervisor with latched fault code and coded yellow lamp flashing.
//
// Contract
// - Codes 1-10: N flashes, pause, repeat.
// - Codes 11-15: 1,2,3,5,6 double flashes, pause.
// - Code 16 flashes continuously.
// - Supply undervoltage code 1; overheat code 2.
// - Current-control timeout raises code 3.
// - Phase failure 1/2/3 raises codes 4/5/6.
// - Wrong phase sequence raises code 7.
// - Frequency or zero-crossing failure raises code 8.
// - Bypass current above 4x raises code 9.
// - Current below 12.5 percent raises code 10.
// - Current above 8.5x raises code 11.
// - Thermal model device 12, motor 13.
// - Mains overvoltage 14; no mains 15.
// - Reset held 5s in stop: manual trip.
// - Any fault latches, red lamp lit.
// - Reset key accepted only without start.
// - Reset key keeps thermal memory.
// - Power cycle clears fault and memory.
// - Fault opens normally closed relay.
// - Fault flashing uses a constant rate.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fbi_defs.svh"
module fbi_fault_blink #(
    parameter logic [31:0] T_ON = `FBI_T_ON,
    parameter logic [31:0] T_GAP = `FBI_T_GAP,
    parameter logic [31:0] T_DGAP = `FBI_T_DGAP,
    parameter logic [31:0] T_PAUSE = `FBI_T_PAUSE,
    parameter logic [31:0] HOLD_CYC = 32'(`FBI_HOLD_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [14:0] flt_in,
    input wire logic reset_key,
    input wire logic start_cmd,
    input wire logic stop_mode,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic red_lamp,
    output logic yellow_lamp,
    output logic fault_signal_relay,
    output logic therm_clr
);
    import fbi_pkg::*;

    // Reset synchroniser; the second stage is the design-wide reset.
    // Assertion is asynchronous so the lamps go safe even without a clock,
    // while release is taken on a clock edge so no register starts half a cycle late.
    logic rst_s1_q, rst_s2_q; // First and second release stages.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // Three-stage input synchronisers; a change counts when stages two and three agree.
    localparam int NIN = 18;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_q, s2_q, s3_q, in_q, in_d;
    assign raw = {stop_mode, start_cmd, reset_key, flt_in};
    // One filter cell per input bit. A pin that bounces between two edges never
    // shows two equal late stages, so the clean copy keeps its last agreed value.
    // The price is one extra cycle of latency on every monitor and on the key.
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            // Stage three is only taken once stage two agrees with it.
            assign in_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : in_q[gi];
        end
    endgenerate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            in_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= in_d;
        end
    end
    // Clean views of the filtered inputs.
    // Bit positions follow the order of the raw vector above.
    // The monitors keep their pin order, so bit i stands for code i + 1.
    wire [14:0] flt = in_q[14:0];
    wire key_f = in_q[15];
    wire start_f = in_q[16];
    wire stop_f = in_q[17];

    // Fault latch, key hold counter and software reset request.
    // The latched code is the single source for lamps, relay and status; it
    // only changes from none to a code, or from a code back to none.
    logic [4:0] code_q, code_d; // Latched fault code, zero while healthy.
    logic wait_q, wait_d; // Bus wait state, high while a request is not yet answered.
    logic [31:0] hold_q, hold_d;
    logic key_prev_q, key_prev_d;
    logic sw_key_q, sw_key_d;
    logic therm_clr_q, therm_clr_d;
    logic [4:0] pick;
    logic clear_ok;

    // Priority encoder: the lowest asserted code wins within one cycle.
    // Scanning from the top down lets the lowest bit write last, so it wins
    // without a second comparison chain.
    always_comb begin
        pick = `FBI_CODE_NONE;
        for (int i = 14; i >= 0; i--) begin
            if (flt[i]) begin
                pick = 5'(i + 1);
            end
        end
    end

    // Next fault state, manual trip timing and reset acceptance.
    // The hold counter saturates at the threshold, so a key held far longer than
    // the trip time cannot wrap around and trip a second time.
    always_comb begin
        code_d = code_q;
        hold_d = hold_q;
        key_prev_d = key_f;
        sw_key_d = 1'b0;
        therm_clr_d = 1'b0;
        // A key press, physical rising edge or software pulse, with start removed.
        clear_ok = ((key_f && !key_prev_q) || sw_key_q) && !start_f;
        if (key_f && stop_f && code_q == `FBI_CODE_NONE) begin
            if (hold_q < HOLD_CYC) begin
                hold_d = hold_q + 32'h1;
            end
        end else begin
            hold_d = 32'h0;
        end
        if (code_q == `FBI_CODE_NONE) begin
            // Monitors 1..15 map bit i to code i+1.
            if (pick != `FBI_CODE_NONE) begin
                code_d = pick;
            end else if (hold_q >= HOLD_CYC - 32'h1 && key_f && stop_f) begin
                code_d = `FBI_CODE_MANUAL;
                hold_d = 32'h0;
            end
        end else if (clear_ok) begin
            // Thermal memory is not touched by a key reset.
            code_d = `FBI_CODE_NONE;
        end
        // A write takes effect only in the cycle in which waitrequest is low, so
        // a held request pulses the key and the thermal clear exactly once.
        if (avs_write && !wait_q && avs_address == `FBI_ADDR_CTRL) begin
            sw_key_d = avs_writedata[`FBI_CTRL_RESET_KEY];
            therm_clr_d = avs_writedata[`FBI_CTRL_THERM_CLR];
        end
    end

    // Fault registers; power-on reset clears the code and pulses the thermal clear.
    // The power-on flag stretches the thermal clear one cycle past release so the
    // thermal model sees it even if its own reset lifts on the same edge.
    logic por_clr_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= `FBI_CODE_NONE;
            hold_q <= 32'h0;
            key_prev_q <= 1'b0;
            sw_key_q <= 1'b0;
            therm_clr_q <= 1'b0;
            por_clr_q <= 1'b1;
        end else begin
            code_q <= code_d;
            hold_q <= hold_d;
            key_prev_q <= key_prev_d;
            sw_key_q <= sw_key_d;
            therm_clr_q <= therm_clr_d;
            por_clr_q <= 1'b0;
        end
    end

    // Flash sequencer: constant-rate groups whose count follows the latched code.
    // Codes differ in flash count, in pairing for codes 11-15 and in the pause that code 16 skips;
    // each on and off time is a fixed parameter, which keeps fault flashing apart from the ramp flashing.
    fbi_state_t st_q, st_d;
    logic [31:0] tmr_q, tmr_d;
    logic [3:0] cnt_q, cnt_d;
    logic half_q, half_d;
    logic [3:0] groups;
    logic dbl;

    // Group count per code; a count of four is skipped for double flashes.
    // Double flash codes share the single flash timer; the half flag marks the
    // second flash of a pair, and only that one advances the group count.
    always_comb begin
        dbl = code_q >= `FBI_CODE_DBL_FIRST && code_q < `FBI_CODE_MANUAL;
        case (code_q)
            5'h0b: groups = 4'h1;
            5'h0c: groups = 4'h2;
            5'h0d: groups = 4'h3;
            5'h0e: groups = 4'h5;
            5'h0f: groups = 4'h6;
            default: groups = code_q[3:0];
        endcase
    end

    // Fixed timing parameters give a constant flash rate in fault mode.
    // Each timer load is one less than its length because the zero count is
    // itself a cycle of the phase.
    always_comb begin
        st_d = st_q;
        tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : 32'h0;
        cnt_d = cnt_q;
        half_d = half_q;
        case (st_q)
            FBI_IDLE: begin
                if (code_q != `FBI_CODE_NONE) begin
                    st_d = FBI_ON;
                    tmr_d = T_ON - 32'h1;
                    cnt_d = 4'h1;
                    half_d = 1'b0;
                end
            end
            FBI_ON: begin
                if (tmr_q == 32'h0) begin
                    if (code_q == `FBI_CODE_MANUAL) begin
                        st_d = FBI_GAP;
                        tmr_d = T_GAP - 32'h1;
                    end else if (dbl && !half_q) begin
                        st_d = FBI_GAP;
                        tmr_d = T_DGAP - 32'h1;
                    end else if (cnt_q >= groups) begin
                        st_d = FBI_PAUSE;
                        tmr_d = T_PAUSE - 32'h1;
                    end else begin
                        st_d = FBI_GAP;
                        tmr_d = T_GAP - 32'h1;
                    end
                end
            end
            FBI_GAP: begin
                if (tmr_q == 32'h0) begin
                    st_d = FBI_ON;
                    tmr_d = T_ON - 32'h1;
                    if (dbl && !half_q) begin
                        half_d = 1'b1;
                    end else begin
                        half_d = 1'b0;
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            FBI_PAUSE: begin
                if (tmr_q == 32'h0) begin
                    st_d = FBI_IDLE;
                end
            end
            default: st_d = FBI_IDLE;
        endcase
        if (code_q == `FBI_CODE_NONE) begin
            st_d = FBI_IDLE;
        end
    end

    // Lamp and relay next values.
    // They follow the next values so red lamp and relay change on the same edge as the
    // code, and the yellow lamp on the same edge as the sequencer state.
    logic red_d, yel_d, rel_d;
    always_comb begin
        red_d = code_d != `FBI_CODE_NONE;
        rel_d = code_d == `FBI_CODE_NONE;
        yel_d = st_d == FBI_ON;
    end

    // Sequencer and output registers.
    // Every top-level output leaves from a flop, so the relay coil and the lamps
    // never see a combinational glitch.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= FBI_IDLE;
            tmr_q <= 32'h0;
            cnt_q <= 4'h0;
            half_q <= 1'b0;
            red_lamp <= 1'b0;
            yellow_lamp <= 1'b0;
            fault_signal_relay <= 1'b1;
            therm_clr <= 1'b1;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
            half_q <= half_d;
            red_lamp <= red_d;
            yellow_lamp <= yel_d;
            fault_signal_relay <= rel_d;
            therm_clr <= therm_clr_q | por_clr_q;
        end
    end

    // Avalon slave: one wait cycle, then the answer with read data.
    // The wait cycle lets the status word settle before it is registered;
    // back-to-back requests therefore take two cycles each.
    logic [31:0] rd_d; // Next read data word.
    always_comb begin
        wait_d = 1'b1;
        rd_d = avs_readdata;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            case (avs_address)
                `FBI_ADDR_STATUS: rd_d = {24'h0, red_lamp, yellow_lamp, fault_signal_relay, code_q};
                `FBI_ADDR_THERM: rd_d = {31'h0, therm_clr};
                default: rd_d = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            wait_q <= wait_d;
            avs_readdata <= rd_d;
        end
    end
    assign avs_waitrequest = wait_q;

    // Checks on latching, lamps, relay and reset acceptance.
    // Red lamp and relay are registered from the same next value as the code, so
    // they are compared with the code in the same cycle rather than one later.
    property p_relay;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_q != 5'h0) |-> !fault_signal_relay;
    endproperty
    a_relay: assert property (p_relay) else $error("relay not open");
    property p_closed;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_q == 5'h0) |-> fault_signal_relay;
    endproperty
    a_closed: assert property (p_closed) else $error("relay open without fault");
    property p_red;
        @(posedge clk_sys) disable iff (!rst_n) (code_q != 5'h0) |-> red_lamp;
    endproperty
    a_red: assert property (p_red) else $error("red lamp dark in fault");
    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_q != 5'h0 && start_f) |=> (code_q == $past(code_q));
    endproperty
    a_hold: assert property (p_hold) else $error("fault cleared with start on");
    property p_first;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_q == 5'h0 && flt[0]) |=> code_q == 5'h1;
    endproperty
    a_first: assert property (p_first) else $error("lowest code not latched");
    property p_yel;
        @(posedge clk_sys) disable iff (!rst_n) (code_q == 5'h0) |=> !yellow_lamp;
    endproperty
    a_yel: assert property (p_yel) else $error("yellow flashes without fault");
    // The manual trip never enters the long pause, so its flashing is uninterrupted.
    property p_steady;
        @(posedge clk_sys) disable iff (!rst_n)
        (code_q == `FBI_CODE_MANUAL) |-> (st_q != FBI_PAUSE);
    endproperty
    a_steady: assert property (p_steady) else $error("manual trip paused");
    // Covers for a counted code, a double flash code and the manual trip.
    c_fault: cover property (@(posedge clk_sys) code_q == 5'h3 ##1 yellow_lamp);
    c_dbl: cover property (@(posedge clk_sys) code_q == 5'h0e && st_q == FBI_PAUSE);
    c_man: cover property (@(posedge clk_sys) code_q == `FBI_CODE_MANUAL);
endmodule

// ===== design/fbi_defs.svh
// Constant definitions for the fault blink indicator.
`ifndef FBI_DEFS_SVH
`define FBI_DEFS_SVH
// Avalon-MM register byte addresses.
`define FBI_ADDR_CTRL 4'h0
`define FBI_ADDR_STATUS 4'h4
`define FBI_ADDR_THERM 4'h8
// Control register bit positions.
`define FBI_CTRL_RESET_KEY 0
`define FBI_CTRL_THERM_CLR 1
// Fault codes.
`define FBI_CODE_NONE 5'h00
`define FBI_CODE_MANUAL 5'h10
`define FBI_CODE_DBL_FIRST 5'h0b
// Manual trip hold time in milliseconds and cycles at 250 MHz.
`define FBI_HOLD_MS 5000
`define FBI_CLK_KHZ 250000
`define FBI_HOLD_CYC (`FBI_HOLD_MS * `FBI_CLK_KHZ)
// Default flash timing in clock cycles.
`define FBI_T_ON 32'd25000000
`define FBI_T_GAP 32'd25000000
`define FBI_T_DGAP 32'd10000000
`define FBI_T_PAUSE 32'd100000000
`endif

// ===== design/fbi_pkg.sv
// Types shared by the fault blink indicator.
package fbi_pkg;
    // Phases of the flash sequencer.
    typedef enum logic [1:0] {
        FBI_IDLE,
        FBI_ON,
        FBI_GAP,
        FBI_PAUSE
    } fbi_state_t;
endpackage

// ===== tb/fbi_front_model.sv
// Front panel operator and fault monitor model for the fault blink indicator.
`timescale 1ns/1ps
module fbi_front_model (
    input wire logic clk_sys,
    output logic [14:0] flt_in,
    output logic reset_key,
    output logic start_cmd,
    output logic stop_mode
);
    // The panel starts with no fault, key up, no start and run mode.
    initial begin
        flt_in = 15'h0000;
        reset_key = 1'b0;
        start_cmd = 1'b0;
        stop_mode = 1'b0;
    end

    // A monitor fault is a level held long enough to pass the input filter.
    task automatic raise(input logic [14:0] bits, input int hold);
        begin
            @(posedge clk_sys);
            flt_in <= flt_in | bits;
            repeat (hold) @(posedge clk_sys);
        end
    endtask

    // Monitors go quiet again; the latched fault must survive this.
    task automatic quiet();
        begin
            @(posedge clk_sys);
            flt_in <= 15'h0000;
        end
    endtask

    // Stop mode is a level from the drive; it changes just after a clock edge.
    task automatic set_stop(input logic v);
        begin
            @(posedge clk_sys);
            stop_mode <= v;
        end
    endtask

    // A careful operator drops start before pressing; keep_start breaks that on purpose.
    task automatic press(input int hold, input logic keep_start);
        begin
            @(posedge clk_sys);
            start_cmd <= keep_start;
            repeat (2) @(posedge clk_sys);
            reset_key <= 1'b1;
            repeat (hold) @(posedge clk_sys);
            reset_key <= 1'b0;
            repeat (8) @(posedge clk_sys);
            start_cmd <= 1'b0;
        end
    endtask
endmodule

// ===== tb/fault_blink_indicator_tb.sv
// Self-checking testbench for the fault blink indicator.
`timescale 1ns/1ps
module fault_blink_indicator_tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [14:0] flt_in;
    logic reset_key, start_cmd, stop_mode, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, red_lamp, yellow_lamp, fault_signal_relay, therm_clr;
    int therm_cnt = 0; // Clock edges with the thermal clear seen high so far.
    logic prev_y; // Yellow lamp level one edge back.
    int num_errors = 0, compares = 0, r, m;
    int grp [5] = '{1, 2, 3, 5, 6}; // Double flash groups of codes 11 to 15.

    // 250 MHz system clock.
    always #2 clk_sys = ~clk_sys;

    // Short timings keep the run small; all expectations derive from them.
    fbi_fault_blink #(.T_ON(32'd4), .T_GAP(32'd4), .T_DGAP(32'd2), .T_PAUSE(32'd16),
        .HOLD_CYC(32'd200)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .flt_in(flt_in),
        .reset_key(reset_key), .start_cmd(start_cmd), .stop_mode(stop_mode),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .red_lamp(red_lamp), .yellow_lamp(yellow_lamp),
        .fault_signal_relay(fault_signal_relay), .therm_clr(therm_clr));
    fbi_front_model pnl_u (.clk_sys(clk_sys), .flt_in(flt_in), .reset_key(reset_key),
        .start_cmd(start_cmd), .stop_mode(stop_mode));

    // A key reset must never pulse the thermal clear, so any pulse is remembered.
    always @(posedge clk_sys) begin
        if (therm_clr === 1'b1) therm_cnt <= therm_cnt + 1;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        begin
            $display("compares %0d errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            compares++;
            if (got !== exp) begin
                num_errors++;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // One Avalon cycle: held until waitrequest is sampled low, then released.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        begin
            @(posedge clk_sys);
            avs_address <= a;
            avs_writedata <= wd;
            avs_read <= !wr;
            avs_write <= wr;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (avs_waitrequest !== 1'b0 && n < 100);
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            if (n >= 100) begin
                num_errors++;
                test_done();
            end
        end
    endtask

    // Status check of the red lamp, relay and latched code.
    task automatic chk_status(input logic red, input logic [4:0] code);
        begin
            bus(1'b0, 4'h4, 32'h0);
            chk("status", {25'h0, red, !red, code}, {25'h0, rd[7], rd[5], rd[4:0]});
        end
    endtask

    // Counts rising flashes between two pauses, a pause being ten or more dark cycles.
    task automatic flashes(output int rises);
        int lo, n;
        logic prev;
        begin
            rises = 0;
            lo = 0;
            n = 0;
            prev = 1'b0;
            while (lo < 10 && n < 2000) begin
                @(posedge clk_sys);
                n++;
                lo = (yellow_lamp === 1'b1) ? 0 : lo + 1;
            end
            lo = 0;
            while (lo < 10 && n < 2000) begin
                @(posedge clk_sys);
                n++;
                if (yellow_lamp === 1'b1 && prev !== 1'b1) rises++;
                prev = yellow_lamp;
                lo = (yellow_lamp === 1'b1) ? 0 : lo + 1;
            end
            if (n >= 2000) begin
                num_errors++;
                test_done();
            end
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk_status(1'b0, 5'h00);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Every monitor input, one at a time, then cleared by the key.
        for (int i = 0; i < 15; i++) begin
            pnl_u.raise(15'(1) << i, 10);
            pnl_u.quiet();
            chk_status(1'b1, 5'(i + 1));
            flashes(r);
            chk("flashes", (i < 10) ? i + 1 : 2 * grp[i - 10], r);
            m = therm_cnt;
            pnl_u.press(3, 1'b0);
            chk_status(1'b0, 5'h00);
            chk("therm_keep", 32'h0, therm_cnt - m);
        end
        $display("test codes done");
        // A press with start still active is refused; software reset then clears.
        pnl_u.raise(15'h0001, 10);
        pnl_u.quiet();
        pnl_u.press(3, 1'b1);
        chk_status(1'b1, 5'h01);
        bus(1'b1, 4'h0, 32'h1);
        repeat (8) @(posedge clk_sys);
        chk_status(1'b0, 5'h00);
        $display("test reset done");
        // Same-cycle faults favour the lowest code; a later fault loses to the first.
        pnl_u.raise(15'h0108, 10);
        pnl_u.quiet();
        chk_status(1'b1, 5'h04);
        pnl_u.press(3, 1'b0);
        pnl_u.raise(15'h0020, 10);
        pnl_u.raise(15'h0002, 10);
        pnl_u.quiet();
        chk_status(1'b1, 5'h06);
        pnl_u.press(3, 1'b0);
        $display("test order done");
        // A short hold in stop mode does nothing; a full hold trips.
        pnl_u.set_stop(1'b1);
        pnl_u.press(100, 1'b0);
        chk_status(1'b0, 5'h00);
        pnl_u.press(250, 1'b0);
        pnl_u.set_stop(1'b0);
        chk_status(1'b1, 5'h10);
        r = 0;
        m = 0;
        prev_y = yellow_lamp;
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_sys);
            if (yellow_lamp === 1'b1) m = 0;
            else m++;
            if (m > 4) r = 1000;
            if (yellow_lamp === 1'b1 && prev_y !== 1'b1) r++;
            prev_y = yellow_lamp;
        end
        chk("steady_flash", 32'd25, r);
        $display("test trip done");
        // A software thermal clear gives exactly one pulse and the register reads it back idle.
        m = therm_cnt;
        bus(1'b1, 4'h0, 32'h2);
        repeat (4) @(posedge clk_sys);
        chk("therm_sw", 32'h1, therm_cnt - m);
        bus(1'b0, 4'h8, 32'h0);
        chk("therm_reg", 32'h0, rd);
        $display("test therm done");
        // Power cycle clears the fault and the thermal memory.
        rst_b <= 1'b0;
        repeat (12) @(posedge clk_sys);
        chk("therm_clr", 32'h1, {31'h0, therm_clr});
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk_status(1'b0, 5'h00);
        $display("test power done");
        test_done();
    end
endmodule
